// ===== bpc_pkg.sv
// shared constants and types for the balancing and protection configuration block
package bpc_pkg;

    // timing
    localparam int unsigned BPC_CLK_PERIOD_NS  = 10;
    localparam int unsigned BPC_SETTLE_UNIT_MS = 1;
    localparam int unsigned BPC_MS_CYCLES      = (BPC_SETTLE_UNIT_MS * 1000000) / BPC_CLK_PERIOD_NS;

    // register byte addresses
    localparam logic [7:0] BPC_OFF_BAL_CFG     = 8'h00;
    localparam logic [7:0] BPC_OFF_LOW_TEMP    = 8'h04;
    localparam logic [7:0] BPC_OFF_HIGH_TEMP   = 8'h08;
    localparam logic [7:0] BPC_OFF_DIE_LIMIT   = 8'h0C;
    localparam logic [7:0] BPC_OFF_PROT_EN     = 8'h10;
    localparam logic [7:0] BPC_OFF_CTRL        = 8'h14;
    localparam logic [7:0] BPC_OFF_CELL_SEL    = 8'h18;
    localparam logic [7:0] BPC_OFF_BAL_STATUS  = 8'h1C;
    localparam logic [7:0] BPC_OFF_IRQ_STATUS  = 8'h20;
    localparam logic [7:0] BPC_OFF_IRQ_MASK    = 8'h24;

    // reset values
    localparam logic [3:0] BPC_RST_BAL_CFG     = 4'h2;
    localparam logic [7:0] BPC_RST_LOW_TEMP    = 8'hFF;
    localparam logic [7:0] BPC_RST_HIGH_TEMP   = 8'h00;
    localparam logic [7:0] BPC_RST_DIE_LIMIT   = 8'h55;
    localparam logic [7:0] BPC_RST_PROT_EN     = 8'hA1;
    localparam logic [9:0] BPC_RST_IRQ_MASK    = 10'h000;

    // balancing configuration fields
    localparam int BPC_LOCK_BIT   = 0;
    localparam int BPC_DLY_LSB    = 1;
    localparam int BPC_DLY_MSB    = 3;
    localparam int BPC_BAL_CFG_W  = 4;
    localparam int BPC_CTRL_CFG_BIT = 0;

    // protection enable bit positions
    localparam int BPC_CELL_OVERVOLTAGE          = 7;
    localparam int BPC_CELL_UNDERVOLTAGE         = 6;
    localparam int BPC_DISCHARGE_SHORT_CIRCUIT   = 5;
    localparam int BPC_DISCHARGE_OVERCURRENT_ONE = 4;
    localparam int BPC_DISCHARGE_OVERCURRENT_TWO = 3;
    localparam int BPC_CHARGE_OVERCURRENT        = 2;
    localparam int BPC_CURRENT_LATCH             = 1;
    localparam int BPC_REGULATOR_OUTPUT_CHECK    = 0;

    // interrupt status layout: 7:0 safety flags, then block events
    localparam int BPC_STAT_SETTLE  = 8;
    localparam int BPC_STAT_DISCARD = 9;
    localparam int BPC_STAT_W       = 10;

    // balancing status fields
    localparam int BPC_BST_INHIBIT = 0;
    localparam int BPC_BST_SETTLE  = 1;

    // thermistor threshold scale: 256 adc codes per step
    localparam int BPC_THERM_SHIFT = 8;

    typedef enum logic {BPC_SETTLE_IDLE, BPC_SETTLE_WAIT} bpc_settle_state_type;

endpackage

// ===== bpc_core_if.sv
// signals between the configuration core, the settle timer and the safety flag bank
`timescale 1ns/1ps
interface bpc_core_if;
    logic [2:0]                    balance_settle_delay;
    logic                          balance_on;
    logic                          settle_busy;
    logic                          settle_done;
    logic [7:0]                    fault_in;
    logic [7:0]                    prot_enable;
    logic [1:0]                    block_events;
    logic                          status_clear;
    logic [bpc_pkg::BPC_STAT_W-1:0] status;

    modport core   (output balance_settle_delay, balance_on, fault_in, prot_enable, block_events,
                    status_clear, input settle_busy, settle_done, status);
    modport settle (input balance_settle_delay, balance_on, output settle_busy, settle_done);
    modport flags  (input fault_in, prot_enable, block_events, status_clear, output status);
endinterface

// ===== bpc_settle_timer.sv
// settle delay between end of balancing and the next cell measurement
`timescale 1ns/1ps
module bpc_settle_timer #(
    parameter int unsigned CYCLES_PER_MS = bpc_pkg::BPC_MS_CYCLES
) (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // core link
    bpc_core_if.settle  core
);
    bpc_pkg::bpc_settle_state_type state_q;
    logic [31:0] cnt_q;
    logic        done_q;
    logic        bal_prev_q;
    logic        bal_fell;
    logic [31:0] dly_cycles;

    assign bal_fell         = bal_prev_q && !core.balance_on;
    // code n>0 gives 2^(n-1) ms
    assign dly_cycles       = CYCLES_PER_MS << (core.balance_settle_delay - 3'd1);
    assign core.settle_busy = (state_q == bpc_pkg::BPC_SETTLE_WAIT);
    assign core.settle_done = done_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= bpc_pkg::BPC_SETTLE_IDLE;
            cnt_q      <= 32'h0000_0000;
            done_q     <= 1'b0;
            bal_prev_q <= 1'b0;
        end else begin
            bal_prev_q <= core.balance_on;
            done_q     <= 1'b0;
            case (state_q)
                bpc_pkg::BPC_SETTLE_IDLE: begin
                    if (bal_fell) begin
                        if (core.balance_settle_delay == 3'd0) begin
                            done_q <= 1'b1;
                        end else begin
                            cnt_q   <= dly_cycles;
                            state_q <= bpc_pkg::BPC_SETTLE_WAIT;
                        end
                    end
                end
                bpc_pkg::BPC_SETTLE_WAIT: begin
                    // balancing restarted: no measurement is due yet
                    if (core.balance_on) begin
                        state_q <= bpc_pkg::BPC_SETTLE_IDLE;
                    end else if (cnt_q <= 32'h0000_0001) begin
                        done_q  <= 1'b1;
                        state_q <= bpc_pkg::BPC_SETTLE_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 32'h0000_0001;
                    end
                end
                default: state_q <= bpc_pkg::BPC_SETTLE_IDLE;
            endcase
        end
    end

    AST_SETTLE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bpc_pkg::BPC_SETTLE_IDLE && bal_fell && core.balance_settle_delay == 3'd0) |=> done_q)
        else $error("zero settle code did not give an immediate measurement start");
    AST_SETTLE_WAITS: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == bpc_pkg::BPC_SETTLE_IDLE && bal_fell && core.balance_settle_delay != 3'd0)
        |=> (!done_q && core.settle_busy && cnt_q == $past(dly_cycles)))
        else $error("nonzero settle code did not load the settle count");

endmodule // bpc_settle_timer

// ===== bpc_flag_bank.sv
// sticky safety and event flags, cleared by a status read
`timescale 1ns/1ps
module bpc_flag_bank (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // core link
    bpc_core_if.flags  core
);
    logic [bpc_pkg::BPC_STAT_W-1:0] status_q;
    logic [bpc_pkg::BPC_STAT_W-1:0] events;
    logic [7:0]                     gated;

    // only enabled protections raise a flag
    assign gated       = core.fault_in & core.prot_enable;
    assign events      = {core.block_events, gated};
    assign core.status = status_q;

    genvar i;
    generate
        for (i = 0; i < bpc_pkg::BPC_STAT_W; i++) begin : g_flag
            // a new event wins over the read clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_q[i] <= 1'b0;
                end else begin
                    status_q[i] <= events[i] | (status_q[i] & !core.status_clear);
                end
            end
        end
    endgenerate

    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (|gated) |=> ((status_q[7:0] & $past(gated)) == $past(gated)))
        else $error("enabled fault did not set its safety flag");
    AST_FLAG_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
        (status_q[7:0] == 8'h00 && gated == 8'h00) |=> (status_q[7:0] == 8'h00))
        else $error("disabled fault set a safety flag");

endmodule // bpc_flag_bank

// ===== bpc_config.sv
// balancing and protection configuration registers with apb access
// What this block does
// - after balancing stops, wait 0 or 1..64 ms (field bits 3:1) before measuring
// - lock bit 0 set discards host writes to the active balance cell selection
// - reading the cell selection always returns the live balancing status
// - balancing forbidden while thermistor reading exceeds low threshold times 256
// - balancing forbidden while thermistor reading is below high threshold times 256
// - balancing forbidden while die temperature exceeds signed limit, default 85
// - an enabled protection's fault sets its safety flag; disabled ones set none
// - enable mask gates flags only; fet action uses the raw fault separately
// - one enable bit per protection, bit 7 overvoltage to bit 0 regulator, default A1
// - configuration copies into active settings on leaving configuration-update mode
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module bpc_config #(
    parameter int unsigned CYCLES_PER_MS = bpc_pkg::BPC_MS_CYCLES,
    parameter int          CELLS         = 8
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // measurements and faults
    input  wire logic [15:0]        thermistor_input,
    input  wire logic [7:0]         die_temp,
    input  wire logic [7:0]         fault_detect,
    // balancing, measurement and fet side
    output logic [CELLS-1:0]        balance_cells,
    output logic                    balance_inhibit,
    output logic                    meas_start,
    output logic [7:0]              fault_to_fet,
    // interrupt
    output logic                    irq
);
    bpc_core_if core ();

    default clocking cb_main @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // configuration shadows
    logic [bpc_pkg::BPC_BAL_CFG_W-1:0] bal_cfg_q;
    logic [7:0]                        low_temp_q;
    logic [7:0]                        high_temp_q;
    logic [7:0]                        die_limit_q;
    logic [7:0]                        prot_en_q;
    logic                              cfg_mode_q;
    // active copies
    logic [bpc_pkg::BPC_BAL_CFG_W-1:0] act_bal_cfg_q;
    logic [7:0]                        act_low_q;
    logic [7:0]                        act_high_q;
    logic [7:0]                        act_die_q;
    logic [7:0]                        act_en_q;
    // runtime state
    logic [CELLS-1:0]                  cell_sel_q;
    logic [CELLS-1:0]                  balance_cells_q;
    logic                              balance_inhibit_q;
    logic [7:0]                        fault_to_fet_q;
    logic [bpc_pkg::BPC_STAT_W-1:0]    irq_mask_q;
    logic                              irq_q;
    logic                              discard_q;
    logic                              pready_q;
    logic [31:0]                       prdata_q;
    logic                              pslverr_q;

    // apb decode
    logic        access;
    logic        wr_en;
    logic        rd_en;
    logic        hit_bal_cfg;
    logic        hit_low;
    logic        hit_high;
    logic        hit_die;
    logic        hit_en;
    logic        hit_ctrl;
    logic        hit_sel;
    logic        hit_bst;
    logic        hit_ist;
    logic        hit_mask;
    logic        hit_cfg;
    logic        hit_any;
    logic        hit_ro;
    logic        err_d;
    logic        act_lock;
    logic        leave_cfg;
    logic        sel_wr_ok;
    logic        sel_wr_drop;
    logic        forbid;
    logic [15:0] low_limit;
    logic [15:0] high_limit;
    logic [31:0] rdata_d;

    assign access      = psel && penable && !pready_q;
    assign wr_en       = psel && penable && pready_q && pwrite;
    assign rd_en       = psel && penable && pready_q && !pwrite;
    assign hit_bal_cfg = (paddr == bpc_pkg::BPC_OFF_BAL_CFG);
    assign hit_low     = (paddr == bpc_pkg::BPC_OFF_LOW_TEMP);
    assign hit_high    = (paddr == bpc_pkg::BPC_OFF_HIGH_TEMP);
    assign hit_die     = (paddr == bpc_pkg::BPC_OFF_DIE_LIMIT);
    assign hit_en      = (paddr == bpc_pkg::BPC_OFF_PROT_EN);
    assign hit_ctrl    = (paddr == bpc_pkg::BPC_OFF_CTRL);
    assign hit_sel     = (paddr == bpc_pkg::BPC_OFF_CELL_SEL);
    assign hit_bst     = (paddr == bpc_pkg::BPC_OFF_BAL_STATUS);
    assign hit_ist     = (paddr == bpc_pkg::BPC_OFF_IRQ_STATUS);
    assign hit_mask    = (paddr == bpc_pkg::BPC_OFF_IRQ_MASK);
    assign hit_cfg     = hit_bal_cfg || hit_low || hit_high || hit_die || hit_en;
    assign hit_ro      = hit_bst || hit_ist;
    assign hit_any     = hit_cfg || hit_ctrl || hit_sel || hit_ro || hit_mask;
    // configuration writes outside configuration-update mode are refused
    assign err_d       = !hit_any || (pwrite && ((hit_cfg && !cfg_mode_q) || hit_ro));

    assign act_lock    = act_bal_cfg_q[bpc_pkg::BPC_LOCK_BIT];
    assign sel_wr_ok   = wr_en && hit_sel && !act_lock;
    assign sel_wr_drop = wr_en && hit_sel && act_lock;
    assign leave_cfg   = wr_en && hit_ctrl && cfg_mode_q && !pwdata[bpc_pkg::BPC_CTRL_CFG_BIT];

    // thresholds are in steps of 256 adc codes
    assign low_limit  = {act_low_q, 8'h00};
    assign high_limit = {act_high_q, 8'h00};
    assign forbid     = (thermistor_input > low_limit)
                     || (thermistor_input < high_limit)
                     || ($signed(die_temp) > $signed(act_die_q));

    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_bal_cfg) begin
            rdata_d[bpc_pkg::BPC_BAL_CFG_W-1:0] = bal_cfg_q;
        end else if (hit_low) begin
            rdata_d[7:0] = low_temp_q;
        end else if (hit_high) begin
            rdata_d[7:0] = high_temp_q;
        end else if (hit_die) begin
            rdata_d[7:0] = die_limit_q;
        end else if (hit_en) begin
            rdata_d[7:0] = prot_en_q;
        end else if (hit_ctrl) begin
            rdata_d[bpc_pkg::BPC_CTRL_CFG_BIT] = cfg_mode_q;
        end else if (hit_sel) begin
            rdata_d[CELLS-1:0] = balance_cells_q;
        end else if (hit_bst) begin
            rdata_d[bpc_pkg::BPC_BST_INHIBIT] = balance_inhibit_q;
            rdata_d[bpc_pkg::BPC_BST_SETTLE]  = core.settle_busy;
        end else if (hit_ist) begin
            rdata_d[bpc_pkg::BPC_STAT_W-1:0] = core.status;
        end else if (hit_mask) begin
            rdata_d[bpc_pkg::BPC_STAT_W-1:0] = irq_mask_q;
        end
    end

    // core link
    assign core.balance_settle_delay = act_bal_cfg_q[bpc_pkg::BPC_DLY_MSB:bpc_pkg::BPC_DLY_LSB];
    assign core.balance_on           = |balance_cells_q;
    assign core.fault_in             = fault_detect;
    assign core.prot_enable          = act_en_q;
    assign core.block_events         = {discard_q, core.settle_done};
    assign core.status_clear         = rd_en && hit_ist;

    // apb handshake: one wait cycle, data and error registered with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && err_d;
            if (access) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            end
        end
    end

    // configuration shadows and mode bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bal_cfg_q   <= bpc_pkg::BPC_RST_BAL_CFG;
            low_temp_q  <= bpc_pkg::BPC_RST_LOW_TEMP;
            high_temp_q <= bpc_pkg::BPC_RST_HIGH_TEMP;
            die_limit_q <= bpc_pkg::BPC_RST_DIE_LIMIT;
            prot_en_q   <= bpc_pkg::BPC_RST_PROT_EN;
            cfg_mode_q  <= 1'b0;
            irq_mask_q  <= bpc_pkg::BPC_RST_IRQ_MASK;
        end else if (wr_en) begin
            if (hit_bal_cfg && cfg_mode_q) begin
                bal_cfg_q <= pwdata[bpc_pkg::BPC_BAL_CFG_W-1:0];
            end
            if (hit_low && cfg_mode_q) begin
                low_temp_q <= pwdata[7:0];
            end
            if (hit_high && cfg_mode_q) begin
                high_temp_q <= pwdata[7:0];
            end
            if (hit_die && cfg_mode_q) begin
                die_limit_q <= pwdata[7:0];
            end
            if (hit_en && cfg_mode_q) begin
                prot_en_q <= pwdata[7:0];
            end
            if (hit_ctrl) begin
                cfg_mode_q <= pwdata[bpc_pkg::BPC_CTRL_CFG_BIT];
            end
            if (hit_mask) begin
                irq_mask_q <= pwdata[bpc_pkg::BPC_STAT_W-1:0];
            end
        end
    end

    // active settings follow the shadows only when configuration mode ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_bal_cfg_q <= bpc_pkg::BPC_RST_BAL_CFG;
            act_low_q     <= bpc_pkg::BPC_RST_LOW_TEMP;
            act_high_q    <= bpc_pkg::BPC_RST_HIGH_TEMP;
            act_die_q     <= bpc_pkg::BPC_RST_DIE_LIMIT;
            act_en_q      <= bpc_pkg::BPC_RST_PROT_EN;
        end else if (leave_cfg) begin
            act_bal_cfg_q <= bal_cfg_q;
            act_low_q     <= low_temp_q;
            act_high_q    <= high_temp_q;
            act_die_q     <= die_limit_q;
            act_en_q      <= prot_en_q;
        end
    end

    // balancing selection, gating and fault pass-through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_sel_q        <= '0;
            balance_cells_q   <= '0;
            balance_inhibit_q <= 1'b0;
            fault_to_fet_q    <= 8'h00;
            discard_q         <= 1'b0;
            irq_q             <= 1'b0;
        end else begin
            if (sel_wr_ok) begin
                cell_sel_q <= pwdata[CELLS-1:0];
            end
            discard_q         <= sel_wr_drop;
            balance_inhibit_q <= forbid;
            balance_cells_q   <= forbid ? '0 : cell_sel_q;
            fault_to_fet_q    <= fault_detect;
            irq_q             <= |(core.status & irq_mask_q);
        end
    end

    bpc_settle_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_settle (
        .pclk    (pclk),
        .presetn (presetn),
        .core    (core)
    );

    bpc_flag_bank u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .core    (core)
    );

    assign pready          = pready_q;
    assign prdata          = prdata_q;
    assign pslverr         = pslverr_q;
    assign balance_cells   = balance_cells_q;
    assign balance_inhibit = balance_inhibit_q;
    assign meas_start      = core.settle_done;
    assign fault_to_fet    = fault_to_fet_q;
    assign irq             = irq_q;

    AST_LOCK_DISCARD: assert property (@(posedge pclk) disable iff (!presetn)
        sel_wr_drop |=> ($stable(cell_sel_q) && discard_q))
        else $error("locked cell selection write was not discarded");
    AST_UNLOCK_ACCEPT: assert property (@(posedge pclk) disable iff (!presetn)
        sel_wr_ok |=> (cell_sel_q == $past(pwdata[CELLS-1:0])))
        else $error("unlocked cell selection write was not taken");
    AST_SEL_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit_sel) |=> (pready_q && prdata_q[CELLS-1:0] == $past(balance_cells_q)))
        else $error("cell selection read did not return balancing status");
    AST_LOW_TEMP: assert property (@(posedge pclk) disable iff (!presetn)
        (thermistor_input > {act_low_q, 8'h00}) |=> (balance_inhibit_q && balance_cells_q == '0))
        else $error("balancing allowed above the low temperature threshold");
    AST_HIGH_TEMP: assert property (@(posedge pclk) disable iff (!presetn)
        (thermistor_input < {act_high_q, 8'h00}) |=> (balance_inhibit_q && balance_cells_q == '0))
        else $error("balancing allowed below the high temperature threshold");
    AST_DIE_TEMP: assert property (@(posedge pclk) disable iff (!presetn)
        ($signed(die_temp) > $signed(act_die_q)) |=> balance_inhibit_q)
        else $error("balancing allowed above the die temperature limit");
    AST_FET_RAW: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (fault_to_fet_q == $past(fault_detect)))
        else $error("fet fault path depends on the enable mask");
    AST_ACTIVE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_mode_q && !leave_cfg) |=> $stable(act_en_q) && $stable(act_bal_cfg_q))
        else $error("active settings changed inside configuration-update mode");
    AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit_bal_cfg) |=> (prdata_q[31:4] == 28'h0000000))
        else $error("reserved balancing configuration bits read nonzero");

    // bus, configuration, gating, settle and interrupt checks
    AST_LOCK_NO_ERROR: assert property (
        sel_wr_drop
        |-> !pslverr_q)
        else $error("locked selection write reported an error");

    AST_ACTIVE_COPY: assert property (
        leave_cfg
        |=> (act_en_q == $past(prot_en_q) && act_bal_cfg_q == $past(bal_cfg_q)))
        else $error("leaving update mode did not copy the settings");

    AST_CFG_REFUSED: assert property (
        (wr_en && hit_cfg && !cfg_mode_q)
        |=> ($stable(prot_en_q) && $stable(bal_cfg_q) && $stable(low_temp_q)))
        else $error("configuration write outside update mode took effect");

    AST_RSVD_IGNORED: assert property (
        (wr_en && hit_bal_cfg && cfg_mode_q)
        |=> (bal_cfg_q == $past(pwdata[bpc_pkg::BPC_BAL_CFG_W-1:0])))
        else $error("balancing configuration write kept reserved bits");

    AST_GATE_PASS: assert property (
        !forbid
        |=> (!balance_inhibit_q && balance_cells_q == $past(cell_sel_q)))
        else $error("balancing blocked with temperatures in range");

    AST_SETTLE_ABORT: assert property (
        (core.settle_busy && core.balance_on)
        |=> !core.settle_done)
        else $error("settle ended although balancing restarted");

    AST_MEAS_PULSE: assert property (
        core.settle_done
        |=> !core.settle_done)
        else $error("measurement start stood longer than one cycle");

    AST_IRQ_LEVEL: assert property (
        1'b1
        |=> (irq_q == (|$past(core.status & irq_mask_q))))
        else $error("interrupt does not follow the unmasked status");

    AST_BAD_ADDR: assert property (
        (access && !hit_any)
        |=> (pready_q && pslverr_q))
        else $error("unmapped address did not raise an error");

endmodule // bpc_config

// ===== balancing_protection_config_tb.sv
// self-checking testbench for the balancing and protection configuration block
`timescale 1ns/1ps
module balancing_protection_config_tb;
    logic        pclk             = 1'b0;
    logic        presetn          = 1'b0;
    logic        psel             = 1'b0;
    logic        penable          = 1'b0;
    logic        pwrite           = 1'b0;
    logic [7:0]  paddr            = 8'h00;
    logic [31:0] pwdata           = 32'h0;
    logic [15:0] thermistor_input = 16'h1000;
    logic [7:0]  die_temp         = 8'h00;
    logic [7:0]  fault_detect     = 8'h00;
    logic        pready, pslverr, balance_inhibit, meas_start, irq;
    logic [31:0] prdata;
    logic [7:0]  balance_cells, fault_to_fet;
    logic [31:0] seed             = 32'h4B3B;
    logic [32:0] exp_q[$];
    int          errors           = 0;
    int          n_compared       = 0;
    logic [7:0]  ra[6]            = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24};
    logic [31:0] rv[6]            = '{32'h2, 32'hFF, 32'h0, 32'h55, 32'hA1, 32'h0};
    logic [15:0] tv[3]            = '{16'hFF01, 16'h0FFF, 16'h1000};
    logic [7:0]  dv[3]            = '{8'h00, 8'h00, 8'h56};

    always #5 pclk = ~pclk;

    bpc_config #(.CYCLES_PER_MS(4), .CELLS(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .thermistor_input(thermistor_input), .die_temp(die_temp),
        .fault_detect(fault_detect), .balance_cells(balance_cells), .balance_inhibit(balance_inhibit),
        .meas_start(meas_start), .fault_to_fet(fault_to_fet), .irq(irq));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        n_compared++;
        if (seen !== expv) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one apb transfer; the monitor compares {pslverr, prdata} at completion
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] expv);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(expv);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            check(33'h0, 33'h1);
            complete_run();
        end
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) if (pready === 1'b1 && exp_q.size() > 0) check({pslverr, prdata}, exp_q.pop_front());

    task automatic wait_start(input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (meas_start !== 1'b1 && n < 40);
        check(33'(n >= lo && n <= hi), 33'h1);
        check({24'h0, balance_inhibit, balance_cells}, 33'h100);
        if (n >= 40) complete_run();
    endtask

    task automatic pulse_faults(input logic [31:0] flags);
        fault_detect <= 8'hFF;
        @(posedge pclk);
        fault_detect <= 8'h00;
        #1 check({25'h0, fault_to_fet}, 33'hFF);
        repeat (2) @(posedge pclk);
        #1 check({32'h0, irq}, 33'h1);
        apb(1'b0, 8'h20, 32'h0, {1'b0, flags});
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) apb(1'b0, ra[i], 32'h0, {1'b0, rv[i]});
        apb(1'b0, 8'h28, 32'h0, 33'h100000000);
        apb(1'b1, 8'h10, 32'h0, 33'h100000000);
        apb(1'b1, 8'h14, 32'h1, 33'h0);
        apb(1'b1, 8'h00, 32'hF3, 33'h0);
        apb(1'b0, 8'h00, 32'h0, 33'h3);
        apb(1'b1, 8'h08, 32'h10, 33'h0);
        apb(1'b1, 8'h14, 32'h0, 33'h0);
        apb(1'b1, 8'h18, 32'h0F, 33'h0);
        apb(1'b0, 8'h18, 32'h0, 33'h0);
        apb(1'b0, 8'h20, 32'h0, 33'h200);
        apb(1'b1, 8'h14, 32'h1, 33'h0);
        apb(1'b1, 8'h00, 32'h2, 33'h0);
        apb(1'b1, 8'h14, 32'h0, 33'h0);
        apb(1'b1, 8'h18, 32'h0F, 33'h0);
        apb(1'b0, 8'h18, 32'h0, 33'h0F);
        for (int i = 0; i < 3; i++) begin
            thermistor_input <= tv[i];
            die_temp <= dv[i];
            wait_start(4, 12);
            apb(1'b0, 8'h18, 32'h0, 33'h0);
            seed = lfsr_next(seed);
            thermistor_input <= 16'h1000 + {1'b0, seed[14:0]};
            die_temp <= 8'h55;
            apb(1'b0, 8'h18, 32'h0, 33'h0F);
        end
        apb(1'b0, 8'h20, 32'h0, 33'h100);
        apb(1'b1, 8'h24, 32'h3FF, 33'h0);
        pulse_faults(32'hA1);
        repeat (2) @(posedge pclk);
        #1 check({32'h0, irq}, 33'h0);
        apb(1'b1, 8'h14, 32'h1, 33'h0);
        apb(1'b1, 8'h10, 32'h5E, 33'h0);
        apb(1'b1, 8'h00, 32'h0, 33'h0);
        apb(1'b1, 8'h14, 32'h0, 33'h0);
        pulse_faults(32'h5E);
        check({24'h0, balance_inhibit, balance_cells}, 33'h0F);
        thermistor_input <= 16'hFF01;
        wait_start(1, 3);
        apb(1'b0, 8'h20, 32'h0, 33'h100);
        complete_run();
    end
endmodule // balancing_protection_config_tb
